// [logic/ptf_frame.v]
// Phase-encoded read framing logic: reference, clocks, pre/postamble, marks, parity
//
// The register addresses and the AHB-Lite register port are this design's own decisions.
`include "ptf_defines.vh"
module ptf_frame #(
  parameter TRACKS = 9
) (
  input  wire              MCLK,
  input  wire              RST,
  // Bus
  input  wire              HSEL,
  input  wire [7:0]        HADDR,
  input  wire [1:0]        HTRANS,
  input  wire              HWRITE,
  input  wire [2:0]        HSIZE,
  input  wire [31:0]       HWDATA,
  input  wire              HREADY,
  output wire              HREADYOUT,
  output wire              HRESP,
  output reg  [31:0]       HRDATA,
  // Tape read side
  input  wire [TRACKS-1:0] READ_DATA,
  input  wire [TRACKS-1:0] TRACK_DEAD,
  input  wire              TAPE_READ_STROBE,
  input  wire              OSC_CLOCK,
  // Controller side events
  input  wire              RECORD_START,
  input  wire              CHAR_LOAD,
  input  wire              CHAR_UNLOAD,
  input  wire              CHAR_ALL_ONES,
  input  wire              CHAR_ALL_ZEROS,
  input  wire              UNLOAD_ALL_ONES,
  input  wire              PREAMBLE_BIT,
  input  wire              PREAMBLE_END,
  input  wire              FILEMARK_CAND,
  input  wire              READ_PARITY_FAIL,
  input  wire              WRITE_FILEMARK,
  input  wire [TRACKS-1:0] WRITE_DATA_IN,
  // Outputs
  output reg  [TRACKS-1:0] READ_DATA_OUT,
  output reg  [TRACKS-1:0] TRANSITION,
  output reg  [TRACKS-1:0] WRITE_DATA_OUT,
  output reg               DECODER_CLOCK_GATED,
  output reg               OSC_REFERENCE_OUT,
  output reg               OSC_REFERENCE_HALF,
  output reg  [3:0]        OSC_REF_TRACK_SEL,
  output reg               OSC_REF_FROM_TRACK,
  output reg               LOCK,
  output reg               ALL_TRACKS_DEAD,
  output reg               POSTAMBLE_VALID,
  output reg               PE_FILEMARK_FOUND,
  output reg               PARITY_ERROR
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  wire [TRACKS-1:0] rd_s;
  wire [TRACKS-1:0] dead_s;
  wire [1:0]        clk_s;

  ptf_sync #(.W(TRACKS)) u_sync_rd (.clk(MCLK), .rst(RST), .din(READ_DATA), .dout(rd_s));
  ptf_sync #(.W(TRACKS)) u_sync_dt (.clk(MCLK), .rst(RST), .din(TRACK_DEAD), .dout(dead_s));
  ptf_sync #(.W(2)) u_sync_ck (
    .clk  (MCLK),
    .rst  (RST),
    .din  ({TAPE_READ_STROBE, OSC_CLOCK}),
    .dout (clk_s)
  );

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  wire [7:0] addr_q;
  wire       wr_q;
  wire       rd_en;
  reg  [7:0] ctrl_q;
  reg        perr_clr_pulse;

  ptf_ahb u_ahb (
    .clk       (MCLK),
    .rst       (RST),
    .hsel      (HSEL),
    .haddr     (HADDR),
    .htrans    (HTRANS),
    .hwrite    (HWRITE),
    .hready    (HREADY),
    .hreadyout (HREADYOUT),
    .hresp     (HRESP),
    .addr_q    (addr_q),
    .wr_q      (wr_q),
    .rd_en     (rd_en)
  );

  // Control bits: 0 PE mode, 1 reverse, 2 seven-track, 3 track ref, 4 count enable
  wire pe_mode      = ctrl_q[0];
  wire space_rev    = ctrl_q[1];
  wire seven_track  = ctrl_q[2];
  wire track_ref_sw = ctrl_q[3];
  wire cnt_en       = ctrl_q[4];

  // Control write; bit 7 write clears parity status
  always @(posedge MCLK)
  begin
    if (RST)
    begin
      ctrl_q         <= `PTF_CTRL_RESET;
      perr_clr_pulse <= 1'b0;
    end
    else
    begin
      perr_clr_pulse <= 1'b0;
      if (wr_q && addr_q == `PTF_ADDR_CTRL)
      begin
        ctrl_q         <= {1'b0, HWDATA[6:0]};
        perr_clr_pulse <= HWDATA[7];
      end
    end
  end

  reg [5:0] zero_cnt_q;
  reg [5:0] ones_cnt_q;
  reg       cand_q;

  // Read mux on the address-phase HADDR, registered for the data phase
  always @(posedge MCLK)
  begin
    if (RST)
      HRDATA <= 32'h0;
    else if (rd_en)
    begin
      case (HADDR)
        `PTF_ADDR_CTRL: HRDATA <= {24'h0, ctrl_q};
        `PTF_ADDR_STAT: HRDATA <= {20'h0, OSC_REF_TRACK_SEL, 1'b0, cand_q, LOCK,
                                   ALL_TRACKS_DEAD, POSTAMBLE_VALID,
                                   PE_FILEMARK_FOUND, PARITY_ERROR, OSC_REF_FROM_TRACK};
        `PTF_ADDR_CNT:  HRDATA <= {20'h0, ones_cnt_q, zero_cnt_q};
        default:        HRDATA <= 32'h0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Clocks and reference
  // ---------------------------------------------------------------
  reg [7:0] div_q;
  reg       osc_d1_q;
  wire      osc_tick = clk_s[0] & ~osc_d1_q;

  // Crystal reference divider and its half rate
  always @(posedge MCLK)
  begin
    if (RST)
    begin
      div_q              <= 8'h00;
      OSC_REFERENCE_OUT  <= 1'b0;
      OSC_REFERENCE_HALF <= 1'b0;
    end
    else if (div_q == `PTF_OSC_DIV - 8'd1)
    begin
      div_q             <= 8'h00;
      OSC_REFERENCE_OUT <= ~OSC_REFERENCE_OUT;
      if (OSC_REFERENCE_OUT)
        OSC_REFERENCE_HALF <= ~OSC_REFERENCE_HALF;
    end
    else
      div_q <= div_q + 8'd1;
  end

  // Reference track choice and decoder clock
  always @(posedge MCLK)
  begin
    if (RST)
    begin
      OSC_REF_TRACK_SEL   <= `PTF_REF_TRACK_A;
      OSC_REF_FROM_TRACK  <= 1'b0;
      DECODER_CLOCK_GATED <= 1'b0;
      osc_d1_q            <= 1'b0;
    end
    else
    begin
      osc_d1_q           <= clk_s[0];
      OSC_REF_FROM_TRACK <= track_ref_sw;
      DECODER_CLOCK_GATED <= pe_mode ? clk_s[0] : clk_s[1];
      if (dead_s[OSC_REF_TRACK_SEL])
      begin
        if (OSC_REF_TRACK_SEL == `PTF_REF_TRACK_A && !dead_s[`PTF_REF_TRACK_B])
          OSC_REF_TRACK_SEL <= `PTF_REF_TRACK_B;
        else if (!dead_s[`PTF_REF_TRACK_A])
          OSC_REF_TRACK_SEL <= `PTF_REF_TRACK_A;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read data path
  // ---------------------------------------------------------------
  reg [TRACKS-1:0] delayed_q;
  wire             inv = pe_mode | space_rev;

  // Per-track invert, delay and compare on oscillator ticks
  genvar g;
  generate
    for (g = 0; g < TRACKS; g = g + 1)
    begin : g_trk
      always @(posedge MCLK)
      begin
        if (RST)
        begin
          READ_DATA_OUT[g] <= 1'b0;
          delayed_q[g]     <= 1'b0;
          TRANSITION[g]    <= 1'b0;
        end
        else
        begin
          READ_DATA_OUT[g] <= rd_s[g] ^ inv;
          if (osc_tick)
          begin
            delayed_q[g]  <= READ_DATA_OUT[g];
            TRANSITION[g] <= READ_DATA_OUT[g] ^ delayed_q[g];
          end
        end
      end
    end
  endgenerate

  // Write masking for file marks and seven-track
  always @(posedge MCLK)
  begin
    if (RST)
      WRITE_DATA_OUT <= {TRACKS{1'b0}};
    else
    begin
      WRITE_DATA_OUT <= WRITE_DATA_IN;
      if (WRITE_FILEMARK)
      begin
        WRITE_DATA_OUT[`PTF_WFM_TRACK_LO] <= 1'b0;
        WRITE_DATA_OUT[`PTF_WFM_TRACK_HI] <= 1'b0;
      end
      if (seven_track || WRITE_FILEMARK)
        WRITE_DATA_OUT[`PTF_SEVEN_TRACK_BIT] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Preamble, lock and dead tracks
  // ---------------------------------------------------------------
  reg [5:0] pre_cnt_q;
  wire      all_dead_raw = &dead_s;
  wire      single_dead  = (dead_s != {TRACKS{1'b0}}) &&
                           ((dead_s & (dead_s - {{(TRACKS-1){1'b0}}, 1'b1})) == {TRACKS{1'b0}});

  // Preamble bit count gates lock and all-tracks-dead
  always @(posedge MCLK)
  begin
    if (RST || RECORD_START)
    begin
      pre_cnt_q       <= 6'd0;
      LOCK            <= 1'b0;
      ALL_TRACKS_DEAD <= 1'b0;
    end
    else
    begin
      if (PREAMBLE_BIT && pre_cnt_q != 6'h3f)
        pre_cnt_q <= pre_cnt_q + 6'd1;
      if (pre_cnt_q >= `PTF_LOCK_BITS)
        LOCK <= 1'b1;
      ALL_TRACKS_DEAD <= pe_mode && all_dead_raw &&
                         (pre_cnt_q >= `PTF_PRE_DEAD_BITS);
    end
  end

  // ---------------------------------------------------------------
  // Postamble candidate and validation
  // ---------------------------------------------------------------
  wire length_check  = cand_q && (zero_cnt_q >= `PTF_POST_MIN);
  wire post_error    = cand_q && (zero_cnt_q <= `PTF_POST_MAX) && !CHAR_ALL_ONES;
  wire check_gated   = length_check & post_error;
  wire false_post    = cand_q && CHAR_LOAD && !CHAR_ALL_ZEROS && !check_gated;

  // Candidate tracking and zero run count
  always @(posedge MCLK)
  begin
    if (RST || RECORD_START)
    begin
      cand_q          <= 1'b0;
      zero_cnt_q      <= 6'd0;
      ones_cnt_q      <= 6'd0;
      POSTAMBLE_VALID <= 1'b0;
    end
    else
    begin
      if (cnt_en)
      begin
        if (CHAR_LOAD && CHAR_ALL_ONES && !(CHAR_UNLOAD && UNLOAD_ALL_ONES))
          ones_cnt_q <= ones_cnt_q + 6'd1;
        else if (CHAR_UNLOAD && UNLOAD_ALL_ONES && !(CHAR_LOAD && CHAR_ALL_ONES)
                 && ones_cnt_q != 6'd0)
          ones_cnt_q <= ones_cnt_q - 6'd1;
      end
      if (CHAR_LOAD)
      begin
        if (CHAR_ALL_ONES)
        begin
          cand_q     <= 1'b1;
          zero_cnt_q <= 6'd0;
        end
        else if (CHAR_ALL_ZEROS && cand_q)
        begin
          if (zero_cnt_q == `PTF_POST_MAX)
          begin
            cand_q          <= 1'b0;
            POSTAMBLE_VALID <= 1'b0;
          end
          else
            zero_cnt_q <= zero_cnt_q + 6'd1;
        end
        else
          cand_q <= 1'b0;
      end
      if (check_gated && !CHAR_LOAD)
        POSTAMBLE_VALID <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // File mark and parity status
  // ---------------------------------------------------------------
  reg fm_pend_q;

  // Pending mark cancelled by preamble end; parity sticky
  always @(posedge MCLK)
  begin
    if (RST)
    begin
      fm_pend_q         <= 1'b0;
      PE_FILEMARK_FOUND <= 1'b0;
      PARITY_ERROR      <= 1'b0;
    end
    else
    begin
      if (RECORD_START)
        fm_pend_q <= 1'b0;
      else if (pe_mode && PREAMBLE_END)
        fm_pend_q <= 1'b0;
      else if (pe_mode && FILEMARK_CAND)
        fm_pend_q <= 1'b1;
      if (RECORD_START)
        PE_FILEMARK_FOUND <= 1'b0;
      else if (PREAMBLE_END)
        PE_FILEMARK_FOUND <= 1'b0;
      else if (pe_mode && fm_pend_q && ALL_TRACKS_DEAD)
        PE_FILEMARK_FOUND <= 1'b1;
      // Set wins over software clear
      if (READ_PARITY_FAIL || (false_post && !single_dead))
        PARITY_ERROR <= 1'b1;
      else if (perr_clr_pulse || RECORD_START)
        PARITY_ERROR <= 1'b0;
    end
  end

  // HSIZE unused: full-word accesses only
  wire unused_ok = &{1'b0, HSIZE};
endmodule

// [logic/ptf_defines.vh]
// Shared constants for the phase-encoded read framing block
`ifndef PTF_DEFINES_VH
`define PTF_DEFINES_VH
`define PTF_CLK_HZ          10000000
`define PTF_POST_MIN        6'd32
`define PTF_POST_MAX        6'd48
`define PTF_PRE_DEAD_BITS   6'd16
`define PTF_LOCK_BITS       6'd32
`define PTF_REF_TRACK_A     4'd2
`define PTF_REF_TRACK_B     4'd6
`define PTF_WFM_TRACK_LO    3
`define PTF_WFM_TRACK_HI    4
`define PTF_SEVEN_TRACK_BIT 1
`define PTF_OSC_DIV         8'd4
`define PTF_ADDR_CTRL       8'h00
`define PTF_ADDR_STAT       8'h04
`define PTF_ADDR_CNT        8'h08
`define PTF_CTRL_RESET      8'h00
`endif

// [logic/ptf_sync.v]
// Two-flop synchroniser, one per bit
module ptf_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] meta_q;

  // First stage read only by the second
  always @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= {W{1'b0}};
      dout   <= {W{1'b0}};
    end
    else
    begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// [logic/ptf_ahb.v]
// AHB-Lite slave front end: address capture and write/read strobes
module ptf_ahb (
  input  wire        clk,
  input  wire        rst,
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [7:0]  addr_q,
  output reg         wr_q,
  output wire        rd_en
);
  // Accept a valid transfer in the address phase
  wire take = hsel & htrans[1] & hready;

  always @(posedge clk)
  begin
    if (rst)
    begin
      addr_q <= 8'h00;
      wr_q   <= 1'b0;
    end
    else
    begin
      if (take)
        addr_q <= haddr;
      wr_q <= take & hwrite;
    end
  end

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign rd_en     = take & ~hwrite;
endmodule

// [verif/ptf_frame_props.sv]
// Concurrent checks on the framing block ports
`include "ptf_defines.vh"
module ptf_frame_chk #(
  parameter TRACKS = 9
) (
  input logic              MCLK,
  input logic              RST,
  input logic              HREADYOUT,
  input logic              HRESP,
  input logic [TRACKS-1:0] WRITE_DATA_IN,
  input logic              WRITE_FILEMARK,
  input logic [TRACKS-1:0] WRITE_DATA_OUT,
  input logic              READ_PARITY_FAIL,
  input logic              PARITY_ERROR,
  input logic              RECORD_START,
  input logic              POSTAMBLE_VALID,
  input logic              PREAMBLE_END,
  input logic              PE_FILEMARK_FOUND,
  input logic [TRACKS-1:0] TRACK_DEAD,
  input logic [3:0]        OSC_REF_TRACK_SEL,
  input logic              OSC_REFERENCE_OUT,
  input logic              OSC_REFERENCE_HALF
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (RST);
  // -----------------------------------
  // Bus, reference and write path
  // -----------------------------------
  a_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus answer not ready or not okay");
  a_ref_legal: assert property (OSC_REF_TRACK_SEL == `PTF_REF_TRACK_A ||
    OSC_REF_TRACK_SEL == `PTF_REF_TRACK_B)
    else $error("reference track not one of the two");
  a_ref_to_alt: assert property ((TRACK_DEAD[`PTF_REF_TRACK_A] &&
    !TRACK_DEAD[`PTF_REF_TRACK_B]) [*6] |-> OSC_REF_TRACK_SEL == `PTF_REF_TRACK_B)
    else $error("reference stayed on dead track");
  a_ref_back: assert property ((TRACK_DEAD[`PTF_REF_TRACK_B] &&
    !TRACK_DEAD[`PTF_REF_TRACK_A]) [*6] |-> OSC_REF_TRACK_SEL == `PTF_REF_TRACK_A)
    else $error("reference stayed on dead track");
  a_fm_mask: assert property (!$past(RST) && $past(WRITE_FILEMARK) |->
    !WRITE_DATA_OUT[`PTF_WFM_TRACK_LO] && !WRITE_DATA_OUT[`PTF_WFM_TRACK_HI] &&
    !WRITE_DATA_OUT[`PTF_SEVEN_TRACK_BIT])
    else $error("file mark tracks not masked");
  a_wr_pass: assert property (!$past(RST) |->
    WRITE_DATA_OUT[TRACKS-1:5] == $past(WRITE_DATA_IN[TRACKS-1:5]))
    else $error("unmasked write data altered");
  // -----------------------------------
  // Status and dividers
  // -----------------------------------
  a_parity_set: assert property (READ_PARITY_FAIL |=> PARITY_ERROR)
    else $error("parity fail not reported");
  a_rec_clear: assert property (RECORD_START |=> !POSTAMBLE_VALID)
    else $error("postamble valid survived record start");
  a_fm_cancel: assert property (PREAMBLE_END |=> !PE_FILEMARK_FOUND)
    else $error("file mark kept after preamble end");
  a_ref_div: assert property ($changed(OSC_REFERENCE_OUT) |=>
    $stable(OSC_REFERENCE_OUT) [*3] ##1 $changed(OSC_REFERENCE_OUT))
    else $error("reference divider period wrong");
  a_half_div: assert property ($changed(OSC_REFERENCE_HALF) |=>
    $stable(OSC_REFERENCE_HALF) [*7] ##1 $changed(OSC_REFERENCE_HALF))
    else $error("half reference period wrong");
endmodule
bind ptf_frame ptf_frame_chk #(.TRACKS(TRACKS)) ptf_frame_chk_inst (
  .MCLK(MCLK), .RST(RST), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .WRITE_DATA_IN(WRITE_DATA_IN), .WRITE_FILEMARK(WRITE_FILEMARK),
  .WRITE_DATA_OUT(WRITE_DATA_OUT), .READ_PARITY_FAIL(READ_PARITY_FAIL),
  .PARITY_ERROR(PARITY_ERROR), .RECORD_START(RECORD_START),
  .POSTAMBLE_VALID(POSTAMBLE_VALID), .PREAMBLE_END(PREAMBLE_END),
  .PE_FILEMARK_FOUND(PE_FILEMARK_FOUND), .TRACK_DEAD(TRACK_DEAD),
  .OSC_REF_TRACK_SEL(OSC_REF_TRACK_SEL), .OSC_REFERENCE_OUT(OSC_REFERENCE_OUT),
  .OSC_REFERENCE_HALF(OSC_REFERENCE_HALF)
);

// [verif/ptf_tape_model.sv]
// Tape transport read bus model
module ptf_tape_model (
  input  logic       mclk,
  input  logic       run,
  input  logic [8:0] pat,
  input  logic [8:0] dead,
  output logic [8:0] rdata,
  output logic [8:0] tdead,
  output logic       strobe,
  output logic       osc
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] div_q = 3'h0;
  initial
  begin
    rdata = 9'h000;
    tdead = 9'h000;
    strobe = 1'b0;
    osc = 1'b0;
  end
  // Clock and data only within a frame, churning data between
  always @(posedge mclk)
  begin
    div_q <= div_q + 3'h1;
    tdead <= dead;
    if (run)
    begin
      osc <= div_q[2];
      strobe <= (div_q == 3'h0);
      rdata <= pat;
    end
    else
    begin
      osc <= 1'b0;
      strobe <= 1'b0;
      rdata <= ~rdata;
    end
  end
endmodule

// [verif/tb_ptf_frame.sv]
// Self-checking bench for the framing block
module tb_ptf_frame;
  timeunit 1ns;
  timeprecision 1ns;
  logic        MCLK = 0, RST = 1, HSEL = 0, HWRITE = 0, run = 0;
  logic [7:0]  HADDR = 8'h00;
  logic [1:0]  HTRANS = 2'h0;
  logic [31:0] HWDATA = 32'h0, rdat;
  logic [10:0] ev = 11'h000;
  logic [8:0]  pat = 9'h000, dead = 9'h000, wd = 9'h000;
  wire         HREADYOUT, strobe, osc, LOCK, POSTAMBLE_VALID, PARITY_ERROR;
  wire  [31:0] HRDATA;
  wire  [8:0]  READ_DATA, TRACK_DEAD, READ_DATA_OUT, WRITE_DATA_OUT;
  wire  [3:0]  OSC_REF_TRACK_SEL;
  int          miscompares = 0, compares = 0, cyc = 0;
  int          ns[4] = '{32, 31, 48, 49};
  ptf_tape_model ptf_tape_model_inst (.mclk(MCLK), .run(run), .pat(pat), .dead(dead),
    .rdata(READ_DATA), .tdead(TRACK_DEAD), .strobe(strobe), .osc(osc));
  ptf_frame ptf_frame_inst (.MCLK(MCLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HREADYOUT(HREADYOUT), .HRESP(), .HRDATA(HRDATA), .READ_DATA(READ_DATA),
    .TRACK_DEAD(TRACK_DEAD), .TAPE_READ_STROBE(strobe), .OSC_CLOCK(osc),
    .RECORD_START(ev[0]), .CHAR_LOAD(ev[1]), .CHAR_UNLOAD(ev[2]), .CHAR_ALL_ONES(ev[3]),
    .CHAR_ALL_ZEROS(ev[4]), .UNLOAD_ALL_ONES(ev[5]), .PREAMBLE_BIT(ev[6]),
    .PREAMBLE_END(ev[7]), .FILEMARK_CAND(ev[8]), .READ_PARITY_FAIL(ev[9]),
    .WRITE_FILEMARK(ev[10]), .WRITE_DATA_IN(wd), .READ_DATA_OUT(READ_DATA_OUT),
    .TRANSITION(), .WRITE_DATA_OUT(WRITE_DATA_OUT), .DECODER_CLOCK_GATED(),
    .OSC_REFERENCE_OUT(), .OSC_REFERENCE_HALF(), .OSC_REF_TRACK_SEL(OSC_REF_TRACK_SEL),
    .OSC_REF_FROM_TRACK(), .LOCK(LOCK), .ALL_TRACKS_DEAD(), .POSTAMBLE_VALID(POSTAMBLE_VALID),
    .PE_FILEMARK_FOUND(), .PARITY_ERROR(PARITY_ERROR));
  // -----------------------------------
  // Tasks
  // -----------------------------------
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // One single word transfer, read data kept in rdat
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HADDR <= a;
    HTRANS <= 2'h2;
    HWRITE <= w;
    @(posedge MCLK);
    while (HREADYOUT !== 1'b1) @(posedge MCLK);
    HTRANS <= 2'h0;
    HSEL <= 1'b0;
    HWDATA <= d;
    @(posedge MCLK);
    while (HREADYOUT !== 1'b1) @(posedge MCLK);
    rdat = HRDATA;
  endtask
  task pulse(input logic [10:0] m, input int n);
    repeat (n)
    begin
      ev <= m;
      @(posedge MCLK);
      ev <= 11'h000;
      @(posedge MCLK);
    end
  endtask
  task test_done;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // -----------------------------------
  // Clock, timeout and tests
  // -----------------------------------
  initial forever #50 MCLK = ~MCLK;
  always @(posedge MCLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      miscompares++;
      test_done;
    end
  end
  initial
  begin
    repeat (8) @(posedge MCLK);
    RST <= 1'b0;
    ahb(0, 8'h04, 0);
    chk("status", rdat, 32'h200);
    ahb(0, 8'h0c, 0);
    chk("unmapped", rdat, 32'h0);
    $display("reset test done");
    run <= 1'b1;
    pat <= 9'h0a5;
    for (int c = 0; c < 4; c++)
    begin
      ahb(1, 8'h00, c);
      repeat (6) @(posedge MCLK);
      chk("read data", 32'(READ_DATA_OUT), 32'(pat ^ {9{c != 0}}));
    end
    run <= 1'b0;
    $display("inversion test done");
    wd <= 9'h1ff;
    ahb(1, 8'h00, 0);
    ev <= 11'h400;
    repeat (2) @(posedge MCLK);
    chk("write file mark", 32'(WRITE_DATA_OUT), 32'h1e5);
    ev <= 11'h000;
    ahb(1, 8'h00, 4);
    repeat (2) @(posedge MCLK);
    chk("write seven track", 32'(WRITE_DATA_OUT), 32'h1fd);
    $display("write mask test done");
    pulse(11'h200, 1);
    chk("parity", 32'(PARITY_ERROR), 32'h1);
    ahb(0, 8'h04, 0);
    chk("status parity", rdat & 32'h2, 32'h2);
    ahb(1, 8'h00, 32'h80);
    repeat (2) @(posedge MCLK);
    chk("parity clear", 32'(PARITY_ERROR), 32'h0);
    $display("parity test done");
    dead <= 9'h004;
    repeat (8) @(posedge MCLK);
    chk("ref alt", 32'(OSC_REF_TRACK_SEL), 32'h6);
    dead <= 9'h040;
    repeat (8) @(posedge MCLK);
    chk("ref back", 32'(OSC_REF_TRACK_SEL), 32'h2);
    dead <= 9'h000;
    $display("reference test done");
    pulse(11'h001, 1);
    pulse(11'h040, 31);
    repeat (2) @(posedge MCLK);
    chk("lock early", 32'(LOCK), 32'h0);
    pulse(11'h040, 1);
    repeat (2) @(posedge MCLK);
    chk("lock", 32'(LOCK), 32'h1);
    pulse(11'h080, 1);
    $display("lock test done");
    ahb(1, 8'h00, 32'h10);
    foreach (ns[i])
    begin
      pulse(11'h001, 1);
      pulse(11'h00a, 1);
      pulse(11'h012, ns[i]);
      repeat (2) @(posedge MCLK);
      chk("postamble", 32'(POSTAMBLE_VALID), 32'(ns[i] >= 32 && ns[i] <= 48));
      ahb(0, 8'h08, 0);
      chk("ones tally", 32'(rdat[11:6]), 32'h1);
    end
    pulse(11'h024, 1);
    ahb(0, 8'h08, 0);
    chk("tally down", 32'(rdat[11:6]), 32'h0);
    $display("postamble test done");
    ahb(1, 8'h00, 32'h11);
    pulse(11'h001, 1);
    pulse(11'h040, 16);
    pulse(11'h100, 1);
    dead <= 9'h1ff;
    repeat (8) @(posedge MCLK);
    ahb(0, 8'h04, 0);
    chk("file mark", rdat & 32'h14, 32'h14);
    pulse(11'h080, 1);
    ahb(0, 8'h04, 0);
    chk("file mark cancel", rdat & 32'h4, 32'h0);
    dead <= 9'h000;
    $display("file mark test done");
    test_done;
  end
endmodule
